// ### tb/pcr_mgmt_model.sv
`timescale 1ns/100ps
// ************************************************************
// Management controller on the MAC side of the register bank.
// ************************************************************
module pcr_mgmt_model (
   // Clock.
   input wire logic sys_clk,
   // Management port toward the register bank.
   output logic [4:0] mgmt_addr,
   output logic mgmt_wr_en,
   output logic mgmt_rd_en,
   output logic [15:0] mgmt_wdata,
   input wire logic [15:0] mgmt_rdata,
   input wire logic mgmt_rvalid
);
   // Idle values are junk on purpose, so that a stale address is never mistaken for a request.
   initial begin
      mgmt_addr = 5'h1F;
      mgmt_wr_en = 1'b0;
      mgmt_rd_en = 1'b0;
      mgmt_wdata = 16'hA5A5;
   end

   // One write: strobe held over exactly one rising edge, then the lines show inverted junk.
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      logic [15:0] v;
      v = d;
      if (a === pcr_pkg::ADDR_INT && v[14] && v[15]) begin
         v[15] = 1'b0;
      end
      @(negedge sys_clk);
      mgmt_addr = a;
      mgmt_wdata = v;
      mgmt_wr_en = 1'b1;
      @(negedge sys_clk);
      mgmt_wr_en = 1'b0;
      mgmt_addr = ~a;
      mgmt_wdata = ~v;
   endtask : wr

   // One read: the answer is awaited for a few cycles only; ok stays low if it never comes.
   task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
      int i;
      ok = 1'b0;
      d = 16'hDEAD;
      @(negedge sys_clk);
      mgmt_addr = a;
      mgmt_rd_en = 1'b1;
      @(negedge sys_clk);
      mgmt_rd_en = 1'b0;
      mgmt_addr = ~a;
      for (i = 0; i < 4 && !ok; i++) begin
         if (mgmt_rvalid === 1'b1) begin
            ok = 1'b1;
            d = mgmt_rdata;
         end else begin
            @(negedge sys_clk);
         end
      end
   endtask : rd

   // The controller waits out the soft reset, plus four cycles, before it goes on.
   task automatic wait_soft_reset();
      repeat (pcr_pkg::SOFT_RST_CYCLES + 4) @(negedge sys_clk);
   endtask : wait_soft_reset
endmodule : pcr_mgmt_model

// ### tb/pcr_regs_test.sv
`timescale 1ns/100ps
module pcr_regs_test;
   // ************************************************************
   // Clock, reset and stimulus signals.
   // ************************************************************
   localparam int TIMEOUT_CYCLES = 3000; // Whole run needs well under a thousand cycles.
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] mgmt_addr;
   logic mgmt_wr_en, mgmt_rd_en, mgmt_rvalid;
   logic [15:0] mgmt_wdata, mgmt_rdata, lp_ability_in;
   logic pin, link_up, an_speed_100, full_duplex, tx_active, rx_active, activity, an_restart, lp_load;
   logic phy_soft_reset, mii_drive_en, mii_isolate, autoneg_active, speed_100, loopback_en;
   logic tx_indicator_n, rx_indicator_n;
   logic [15:0] d;
   logic ok;
   int fail_count = 0;
   int n_tests = 0;
   int cycles = 0;

   always #2.5 sys_clk = ~sys_clk;

   pcr_mgmt_model mac (.sys_clk(sys_clk), .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en),
      .mgmt_rd_en(mgmt_rd_en), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid));

   pcr_regs DUT (.sys_clk(sys_clk), .rst_n(rst_n), .mgmt_addr(mgmt_addr), .mgmt_wr_en(mgmt_wr_en),
      .mgmt_rd_en(mgmt_rd_en), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
      .autoneg_hw_enable_pin(pin), .link_up(link_up), .an_speed_100(an_speed_100),
      .full_duplex(full_duplex), .tx_active(tx_active), .rx_active(rx_active), .activity(activity),
      .an_restart(an_restart), .lp_load(lp_load), .lp_ability_in(lp_ability_in),
      .phy_soft_reset(phy_soft_reset), .mii_drive_en(mii_drive_en), .mii_isolate(mii_isolate),
      .autoneg_active(autoneg_active), .speed_100(speed_100), .loopback_en(loopback_en),
      .tx_indicator_n(tx_indicator_n), .rx_indicator_n(rx_indicator_n));

   // ************************************************************
   // Compare and helper tasks.
   // ************************************************************
   task automatic final_report();
      $display("Checks %0d, mismatches %0d.", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : final_report

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk16

   task automatic chk1(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk1

   // A read that never answers counts as a mismatch on the valid flag.
   task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
      mac.rd(a, d, ok);
      chk1(ok, 1'b1);
      chk16(d, exp);
   endtask : rdc

   task automatic pause(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : pause

   // Hang guard: a stuck run is judged failed.
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == TIMEOUT_CYCLES) begin
         fail_count++;
         final_report();
      end
   end

   // ************************************************************
   // Scenarios.
   // ************************************************************
   task automatic t_reset();
      rdc(pcr_pkg::ADDR_CTRL, 16'h1000);
      rdc(pcr_pkg::ADDR_INT, 16'h0000);
      rdc(pcr_pkg::ADDR_LPA, 16'h0000);
      rdc(5'h1F, 16'h0000);
      tx_active = 1'b1;
      rx_active = 1'b1;
      pause(3);
      chk1(tx_indicator_n, 1'b0);
      chk1(rx_indicator_n, 1'b0);
      tx_active = 1'b0;
      rx_active = 1'b0;
   endtask : t_reset

   task automatic t_isolate();
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h1400);
      pause(2);
      chk1(mii_isolate, 1'b1);
      chk1(mii_drive_en, 1'b0);
      rdc(pcr_pkg::ADDR_CTRL, 16'h1400);
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h1800);
      pause(2);
      chk1(mii_drive_en, 1'b1);
      rdc(pcr_pkg::ADDR_CTRL, 16'h1000);
   endtask : t_isolate

   // The core's own speed is kept opposite to the forced bit, so a leak shows.
   task automatic t_autoneg();
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h2000);
      pause(3);
      chk1(autoneg_active, 1'b0);
      chk1(speed_100, 1'b1);
      rdc(pcr_pkg::ADDR_CTRL, 16'h2000);
      an_speed_100 = 1'b1;
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h0000);
      pause(3);
      chk1(speed_100, 1'b0);
      an_speed_100 = 1'b0;
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h3000);
      pause(3);
      chk1(autoneg_active, 1'b1);
      chk1(speed_100, 1'b0);
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h1000);
      pin = 1'b0;
      pause(5);
      chk1(autoneg_active, 1'b0);
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h0000);
      rdc(pcr_pkg::ADDR_CTRL, 16'h1000);
      an_speed_100 = 1'b1;
      pause(3);
      chk1(speed_100, 1'b1);
      pin = 1'b1;
      an_speed_100 = 1'b0;
      pause(5);
      chk1(autoneg_active, 1'b1);
   endtask : t_autoneg

   task automatic t_lpa();
      lp_ability_in = 16'hFFFF;
      lp_load = 1'b1;
      pause(1);
      lp_load = 1'b0;
      rdc(pcr_pkg::ADDR_LPA, 16'hE7FF);
      mac.wr(pcr_pkg::ADDR_LPA, 16'h0000);
      rdc(pcr_pkg::ADDR_LPA, 16'hE7FF);
      an_restart = 1'b1;
      pause(1);
      an_restart = 1'b0;
      rdc(pcr_pkg::ADDR_LPA, 16'h0000);
      lp_ability_in = 16'h0421;
      lp_load = 1'b1;
      pause(1);
      lp_load = 1'b0;
      rdc(pcr_pkg::ADDR_LPA, 16'h0421);
   endtask : t_lpa

   // A control write during the soft reset must leave no trace afterwards.
   task automatic t_soft();
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h5400);
      pause(2);
      chk1(loopback_en, 1'b1);
      rdc(pcr_pkg::ADDR_CTRL, 16'h5400);
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h8000);
      pause(3);
      chk1(phy_soft_reset, 1'b1);
      rdc(pcr_pkg::ADDR_CTRL, 16'h9000);
      mac.wr(pcr_pkg::ADDR_CTRL, 16'h0400);
      mac.wait_soft_reset();
      chk1(phy_soft_reset, 1'b0);
      chk1(loopback_en, 1'b0);
      chk1(mii_isolate, 1'b0);
      rdc(pcr_pkg::ADDR_CTRL, 16'h1000);
      rdc(pcr_pkg::ADDR_LPA, 16'h0000);
   endtask : t_soft

   task automatic t_irq();
      mac.rd(pcr_pkg::ADDR_INT, d, ok);
      mac.wr(pcr_pkg::ADDR_INT, 16'h4000);
      link_up = 1'b1;
      pause(4);
      chk1(tx_indicator_n, 1'b0);
      activity = 1'b1;
      pause(3);
      chk1(rx_indicator_n, 1'b0);
      activity = 1'b0;
      rdc(pcr_pkg::ADDR_INT, 16'h4003);
      rdc(pcr_pkg::ADDR_INT, 16'h4000);
      pause(2);
      chk1(tx_indicator_n, 1'b1);
      an_speed_100 = 1'b1;
      full_duplex = 1'b1;
      pause(4);
      rdc(pcr_pkg::ADDR_INT, 16'h400D);
      mac.wr(pcr_pkg::ADDR_INT, 16'h4100);
      link_up = 1'b0;
      pause(4);
      chk1(tx_indicator_n, 1'b1);
      rdc(pcr_pkg::ADDR_INT, 16'h4102);
      mac.wr(pcr_pkg::ADDR_INT, 16'h4200);
      link_up = 1'b1;
      pause(4);
      chk1(tx_indicator_n, 1'b1);
      rdc(pcr_pkg::ADDR_INT, 16'h4202);
      mac.wr(pcr_pkg::ADDR_INT, 16'h30F0);
      rdc(pcr_pkg::ADDR_INT, 16'h0000);
      mac.wr(pcr_pkg::ADDR_INT, 16'h8000);
      pause(3);
      chk1(rx_indicator_n, 1'b0);
      full_duplex = 1'b0;
      pause(3);
      chk1(rx_indicator_n, 1'b1);
   endtask : t_irq

   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      pin = 1'b1;
      {link_up, an_speed_100, full_duplex, tx_active, rx_active, activity, an_restart, lp_load} = 8'h00;
      lp_ability_in = 16'h0000;
      repeat (16) @(posedge sys_clk);
      @(negedge sys_clk);
      rst_n = 1'b1;
      pause(2);
      t_reset();
      t_isolate();
      t_autoneg();
      t_lpa();
      t_soft();
      t_irq();
      final_report();
   end
endmodule : pcr_regs_test

// ### verilog/pcr_chg_det.sv
`timescale 1ns/100ps
// Sticky change detector: a change sets the flag, a read clears it.
module pcr_chg_det #(
   parameter logic INIT = 1'b0
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Source and flag.
   pcr_chg_if.det ch
);
   logic prev_ff; // Status seen last cycle.
   logic flag_ff; // Sticky flag.

   // Track the status every cycle so a change is seen exactly once.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_ff <= INIT;
      end else begin
         prev_ff <= ch.status;
      end
   end

   // A change in the read cycle still sets the flag, so no event is lost.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag_ff <= 1'b0;
      end else if (ch.status != prev_ff) begin
         flag_ff <= 1'b1;
      end else if (ch.rd_clr || ch.flush) begin
         flag_ff <= 1'b0;
      end
   end

   assign ch.flag = flag_ff;
endmodule : pcr_chg_det

// ### verilog/pcr_chg_if.sv
`timescale 1ns/100ps
// Carries one status source and its sticky change flag.
interface pcr_chg_if;
   logic status; // Current status level.
   logic rd_clr; // Interrupt register read pulse.
   logic flush; // Soft reset in progress.
   logic flag; // Sticky change flag.
   modport det (input status, input rd_clr, input flush, output flag);
   modport ctl (output status, output rd_clr, output flush, input flag);
endinterface : pcr_chg_if

// ### verilog/pcr_pkg.sv
package pcr_pkg;
   // ************************************************************
   // Management register addresses.
   // ************************************************************
   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_LPA = 5'h05;
   localparam logic [4:0] ADDR_INT = 5'h11;

   // ************************************************************
   // Control register field positions.
   // ************************************************************
   localparam int CTRL_RST = 15;
   localparam int CTRL_LOOP = 14;
   localparam int CTRL_FSPEED = 13;
   localparam int CTRL_AN = 12;
   localparam int CTRL_PWRDN = 11;
   localparam int CTRL_ISO = 10;

   // ************************************************************
   // Interrupt register field positions.
   // ************************************************************
   localparam int INT_PEND = 0;
   localparam int INT_CHG_LO = 1;
   localparam int INT_MASTER = 8;
   localparam int INT_MASK_LO = 9;
   localparam int INT_IRQ_MODE = 14;
   localparam int INT_DUP_IND = 15;

   // Bits kept from a partner ability load; everything else reads zero.
   localparam logic [15:0] LPA_VALID_MASK = 16'hE7FF;

   // ************************************************************
   // Values after reset.
   // ************************************************************
   localparam logic RST_ISO = 1'b0;
   localparam logic RST_LOOP = 1'b0;
   localparam logic RST_AN = 1'b1;
   localparam logic RST_FSPEED = 1'b0;
   localparam logic RST_MASTER = 1'b0;
   localparam logic [2:0] RST_SRC_MASK = 3'h0;
   localparam logic RST_IRQ_MODE = 1'b0;
   localparam logic RST_DUP_IND = 1'b0;

   // ************************************************************
   // Timing: the soft PHY reset lasts at least this long.
   // ************************************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int SOFT_RST_NS = 1000;
   localparam int SOFT_RST_CYCLES = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : pcr_pkg

// ### verilog/pcr_regs.sv
`timescale 1ns/100ps
// Overview of operation
// - Isolate tri-states MII outputs, ignores inputs.
// - Writing zero or reset leaves isolate.
// - Isolate bit reads current isolate state.
// - Power-down bit always reads zero.
// - Pin low or bit zero disables autonegotiation.
// - Writing one or reset re-enables autonegotiation.
// - Pin disable ignores writes; reads value held from before.
// - Software disable: forced bit picks speed.
// - Forced bit otherwise inert; reads written value.
// - Loopback bit set, cleared, or reset clears.
// - Reset bit starts reset, clears itself.
// - Other control writes ignored during reset.
// - Pending bit: unmasked flag set; read clears.
// - Change flags set on change, read clears.
// - Master mask blocks every interrupt.
// - Per-source mask blocks that source.
// - Interrupt mode: tx pin interrupt, rx activity.
// - Duplex indicator mode repurposes indicator pin.
// - Partner ability register is read-only.
// - Partner ability cleared on restart or reset.
module pcr_regs (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Management access port.
   input wire logic [4:0] mgmt_addr,
   input wire logic mgmt_wr_en,
   input wire logic mgmt_rd_en,
   input wire logic [15:0] mgmt_wdata,
   output logic [15:0] mgmt_rdata,
   output logic mgmt_rvalid,
   // Hardware autonegotiation enable pin.
   input wire logic autoneg_hw_enable_pin,
   // PHY core status.
   input wire logic link_up,
   input wire logic an_speed_100,
   input wire logic full_duplex,
   input wire logic tx_active,
   input wire logic rx_active,
   input wire logic activity,
   // Autonegotiation engine.
   input wire logic an_restart,
   input wire logic lp_load,
   input wire logic [15:0] lp_ability_in,
   // PHY core control.
   output logic phy_soft_reset,
   output logic mii_drive_en,
   output logic mii_isolate,
   output logic autoneg_active,
   output logic speed_100,
   output logic loopback_en,
   // Indicator pins.
   output logic tx_indicator_n,
   output logic rx_indicator_n
);
   // ************************************************************
   // Pin synchroniser and decode.
   // ************************************************************
   logic an_pin_meta_ff; // First stage, read only by the second.
   logic an_pin_ff; // Synchronised autonegotiation pin.

   // Two stages keep a metastable pin level away from the write decode.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         an_pin_meta_ff <= 1'b0;
         an_pin_ff <= 1'b0;
      end else begin
         an_pin_meta_ff <= autoneg_hw_enable_pin;
         an_pin_ff <= an_pin_meta_ff;
      end
   end

   logic wr_ctrl; // Control register write.
   logic wr_int; // Interrupt register write.
   logic rd_int; // Interrupt register read.
   logic busy; // Soft PHY reset running.
   logic rst_start; // Soft reset request.
   assign wr_ctrl = mgmt_wr_en && (mgmt_addr == pcr_pkg::ADDR_CTRL);
   assign wr_int = mgmt_wr_en && (mgmt_addr == pcr_pkg::ADDR_INT);
   assign rd_int = mgmt_rd_en && (mgmt_addr == pcr_pkg::ADDR_INT);
   // Only a one starts a reset; a zero is ignored.
   assign rst_start = wr_ctrl && !busy && mgmt_wdata[pcr_pkg::CTRL_RST];

   // ************************************************************
   // Soft reset timer.
   // ************************************************************
   // The reset bit reads back as busy, so it clears itself.
   pcr_rst_timer #(
      .CYCLES(pcr_pkg::SOFT_RST_CYCLES)
   ) u_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .start(rst_start),
      .busy(busy)
   );

   // ************************************************************
   // Control register.
   // ************************************************************
   logic iso_ff; // Isolate state.
   logic an_sw_ff; // Software autonegotiation enable.
   logic fspeed_ff; // Software forced speed.
   logic loop_ff; // Software loopback.
   logic ctrl_ok; // Write may change control bits.
   // Writes during reset, or carrying the reset bit, leave bits alone.
   assign ctrl_ok = wr_ctrl && !busy && !mgmt_wdata[pcr_pkg::CTRL_RST];

   // Isolate, loopback and forced speed take reset values while busy.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         iso_ff <= pcr_pkg::RST_ISO;
         loop_ff <= pcr_pkg::RST_LOOP;
         fspeed_ff <= pcr_pkg::RST_FSPEED;
      end else if (busy) begin
         iso_ff <= pcr_pkg::RST_ISO;
         loop_ff <= pcr_pkg::RST_LOOP;
         fspeed_ff <= pcr_pkg::RST_FSPEED;
      end else if (ctrl_ok) begin
         iso_ff <= mgmt_wdata[pcr_pkg::CTRL_ISO];
         loop_ff <= mgmt_wdata[pcr_pkg::CTRL_LOOP];
         fspeed_ff <= mgmt_wdata[pcr_pkg::CTRL_FSPEED];
      end
   end

   // The enable bit only moves while the pin allows autonegotiation.
   // A soft reset still restores the default, even under a pin disable.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         an_sw_ff <= pcr_pkg::RST_AN;
      end else if (busy) begin
         an_sw_ff <= pcr_pkg::RST_AN;
      end else if (ctrl_ok && an_pin_ff) begin
         an_sw_ff <= mgmt_wdata[pcr_pkg::CTRL_AN];
      end
   end

   // ************************************************************
   // Core control outputs.
   // ************************************************************
   // Isolation drops the MII drivers; management stays alive.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mii_drive_en <= 1'b0;
         mii_isolate <= pcr_pkg::RST_ISO;
         loopback_en <= pcr_pkg::RST_LOOP;
         phy_soft_reset <= 1'b0;
      end else begin
         mii_drive_en <= !iso_ff;
         mii_isolate <= iso_ff;
         loopback_en <= loop_ff;
         phy_soft_reset <= busy;
      end
   end

   // Forced speed only counts under a software disable.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         autoneg_active <= 1'b0;
         speed_100 <= 1'b0;
      end else begin
         autoneg_active <= an_pin_ff && an_sw_ff;
         if (an_pin_ff && !an_sw_ff) begin
            speed_100 <= fspeed_ff;
         end else begin
            speed_100 <= an_speed_100;
         end
      end
   end

   // ************************************************************
   // Interrupt register.
   // ************************************************************
   logic master_ff; // Master interrupt mask.
   logic [2:0] src_mask_ff; // Link, speed, duplex masks.
   logic irq_mode_ff; // Interrupt mode enable.
   logic dup_ind_ff; // Duplex indicator mode.
   logic [2:0] flags; // Link, speed, duplex change flags.
   logic irq_pend; // Unmasked change pending.

   // Writable mask and mode bits; reserved bits are not stored.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_ff <= pcr_pkg::RST_MASTER;
         src_mask_ff <= pcr_pkg::RST_SRC_MASK;
         irq_mode_ff <= pcr_pkg::RST_IRQ_MODE;
         dup_ind_ff <= pcr_pkg::RST_DUP_IND;
      end else if (busy) begin
         master_ff <= pcr_pkg::RST_MASTER;
         src_mask_ff <= pcr_pkg::RST_SRC_MASK;
         irq_mode_ff <= pcr_pkg::RST_IRQ_MODE;
         dup_ind_ff <= pcr_pkg::RST_DUP_IND;
      end else if (wr_int) begin
         master_ff <= mgmt_wdata[pcr_pkg::INT_MASTER];
         src_mask_ff <= mgmt_wdata[pcr_pkg::INT_MASK_LO +: 3];
         irq_mode_ff <= mgmt_wdata[pcr_pkg::INT_IRQ_MODE];
         dup_ind_ff <= mgmt_wdata[pcr_pkg::INT_DUP_IND];
      end
   end

   // One sticky detector per status source.
   pcr_chg_if chg[3] ();
   logic [2:0] src_status;
   assign src_status = {full_duplex, an_speed_100, link_up};
   for (genvar i = 0; i < 3; i++) begin : g_chg
      assign chg[i].status = src_status[i];
      assign chg[i].rd_clr = rd_int;
      assign chg[i].flush = busy;
      assign flags[i] = chg[i].flag;
      pcr_chg_det #(
         .INIT(1'b0)
      ) u_det (
         .sys_clk(sys_clk),
         .rst_n(rst_n),
         .ch(chg[i])
      );
   end

   // Pending is decoded, not stored, so a mask write takes effect at once.
   // Master mask overrides the per-source masks.
   assign irq_pend = !master_ff && |(flags & ~src_mask_ff);

   // ************************************************************
   // Link partner ability.
   // ************************************************************
   logic [15:0] lpa_ff; // Abilities from the remote station.

   // Restart or reset wins over a load in the same cycle.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         lpa_ff <= '0;
      end else if (an_restart || busy) begin
         lpa_ff <= '0;
      end else if (lp_load) begin
         lpa_ff <= lp_ability_in & pcr_pkg::LPA_VALID_MASK;
      end
   end

   // ************************************************************
   // Read path.
   // ************************************************************
   logic [15:0] rd_mux; // Read data for the addressed register.

   // Unmapped addresses read zero; writes to this register do nothing.
   always_comb begin
      rd_mux = '0;
      unique case (mgmt_addr)
         pcr_pkg::ADDR_CTRL: begin
            rd_mux[pcr_pkg::CTRL_RST] = busy;
            rd_mux[pcr_pkg::CTRL_LOOP] = loop_ff;
            rd_mux[pcr_pkg::CTRL_FSPEED] = fspeed_ff;
            rd_mux[pcr_pkg::CTRL_AN] = an_sw_ff;
            rd_mux[pcr_pkg::CTRL_PWRDN] = 1'b0;
            rd_mux[pcr_pkg::CTRL_ISO] = iso_ff;
         end
         pcr_pkg::ADDR_INT: begin
            rd_mux[pcr_pkg::INT_PEND] = irq_pend;
            rd_mux[pcr_pkg::INT_CHG_LO +: 3] = flags;
            rd_mux[pcr_pkg::INT_MASTER] = master_ff;
            rd_mux[pcr_pkg::INT_MASK_LO +: 3] = src_mask_ff;
            rd_mux[pcr_pkg::INT_IRQ_MODE] = irq_mode_ff;
            rd_mux[pcr_pkg::INT_DUP_IND] = dup_ind_ff;
         end
         pcr_pkg::ADDR_LPA: begin
            rd_mux = lpa_ff;
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   // Data is captured before the read clears the flags.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mgmt_rdata <= '0;
         mgmt_rvalid <= 1'b0;
      end else begin
         mgmt_rvalid <= mgmt_rd_en;
         if (mgmt_rd_en) begin
            mgmt_rdata <= rd_mux;
         end
      end
   end

   // ************************************************************
   // Indicator pins.
   // ************************************************************
   // Interrupt mode takes precedence should both modes be set.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_indicator_n <= 1'b1;
         rx_indicator_n <= 1'b1;
      end else if (irq_mode_ff) begin
         tx_indicator_n <= !irq_pend;
         rx_indicator_n <= !activity;
      end else begin
         tx_indicator_n <= !tx_active;
         rx_indicator_n <= dup_ind_ff ? !full_duplex : !rx_active;
      end
   end

   // ************************************************************
   // Assertions.
   // ************************************************************
   // The window allows one cycle of slack for the registered start pulse.
   localparam int RST_MAX = pcr_pkg::SOFT_RST_CYCLES + 1;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_iso_drive_off: assert property ($past(iso_ff) |-> !mii_drive_en)
      else $error("MII driven while isolated");
   a_iso_read_back: assert property (mgmt_rd_en && mgmt_addr == pcr_pkg::ADDR_CTRL
      |=> mgmt_rdata[pcr_pkg::CTRL_ISO] == $past(iso_ff) && !mgmt_rdata[pcr_pkg::CTRL_PWRDN])
      else $error("Isolate or power-down read wrong");
   a_an_pin_lock: assert property (ctrl_ok && !an_pin_ff |=> an_sw_ff == $past(an_sw_ff))
      else $error("Enable bit moved under pin disable");
   a_forced_speed: assert property (an_pin_ff && !an_sw_ff |=> speed_100 == $past(fspeed_ff))
      else $error("Forced speed not applied");
   a_rst_self_clear: assert property (rst_start |=> busy[*8] ##[1:RST_MAX] !busy)
      else $error("Soft reset length wrong");
   a_rst_blocks_wr: assert property (busy && wr_ctrl |=> !iso_ff && !loop_ff && an_sw_ff)
      else $error("Control write taken during reset");
   a_pend_read: assert property (rd_int |=> mgmt_rdata[pcr_pkg::INT_PEND] == $past(irq_pend))
      else $error("Pending bit read wrong");
   a_link_chg_set: assert property ($changed(link_up) && !busy |=> flags[0])
      else $error("Link change lost");
   a_master_mask: assert property (master_ff && irq_mode_ff |=> tx_indicator_n)
      else $error("Interrupt despite master mask");
   a_lpa_clear: assert property (an_restart |=> lpa_ff == '0)
      else $error("Partner ability not cleared");
   // A read with no status change in the same cycle must leave every flag clear.
   a_flag_read_clr: assert property (rd_int && !$changed(src_status) |=> flags == 3'h0)
      else $error("Change flag survived a read");
   // Management writes must never reach the partner ability store.
   a_lpa_no_write: assert property (mgmt_wr_en && mgmt_addr == pcr_pkg::ADDR_LPA
      && !(lp_load || an_restart || busy) |=> lpa_ff == $past(lpa_ff))
      else $error("Partner ability changed by a write");

   // Covers show that the soft reset, interrupt, isolate, read-clear and duplex scenarios were reached at all.
   c_soft_reset: cover property (rst_start ##1 busy [*8]);
   c_irq_fire: cover property (irq_mode_ff && !tx_indicator_n);
   c_isolate: cover property (iso_ff ##1 !mii_drive_en);
   c_read_clear: cover property (rd_int && |flags ##1 !(|flags));
   c_dup_mode: cover property (dup_ind_ff && !rx_indicator_n);
endmodule : pcr_regs

// ### verilog/pcr_rst_timer.sv
`timescale 1ns/100ps
// Holds busy for a fixed number of cycles after a start pulse.
module pcr_rst_timer #(
   parameter int CYCLES = pcr_pkg::SOFT_RST_CYCLES
) (
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control.
   input wire logic start,
   output logic busy
);
   localparam int CW = $clog2(CYCLES + 1);
   logic [CW-1:0] cnt_ff; // Cycles still to run.

   // Elaboration check: a zero-length interval could never report busy.
   if (CYCLES < 1) begin : g_bad_cycles
      $error("CYCLES must be at least one");
   end

   // A start while busy restarts the full interval.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else if (start) begin
         cnt_ff <= CW'(CYCLES);
      end else if (cnt_ff != '0) begin
         cnt_ff <= cnt_ff - CW'(1);
      end
   end

   assign busy = (cnt_ff != '0);
endmodule : pcr_rst_timer
